//--- pkg/vmo_pkg.sv
// shared constants for the legacy misc output / sequencer index block
package vmo_pkg;
    localparam int IO_ADDR_W = 16;
    localparam int MEM_ADDR_W = 32;
    localparam int DATA_W = 8;
    // legacy port addresses
    localparam logic [15:0] PORT_MISC_WR = 16'h03C2;
    localparam logic [15:0] PORT_MISC_RD = 16'h03CC;
    localparam logic [15:0] PORT_SEQ_INDEX = 16'h03C4;
    localparam logic [15:0] PORT_SEQ_DATA = 16'h03C5;
    localparam logic [15:0] PORT_MONO_BASE = 16'h03B0;
    localparam logic [15:0] PORT_COLOUR_BASE = 16'h03D0;
    localparam logic [15:0] PORT_RANGE_MASK = 16'hFFF0;
    // legacy memory aperture
    localparam logic [31:0] APERTURE_LO = 32'h000A_0000;
    localparam logic [31:0] APERTURE_HI = 32'h000B_FFFF;
    // misc output fields
    localparam int MISC_IO_SEL_BIT = 0;
    localparam int MISC_APER_EN_BIT = 1;
    localparam int MISC_CLK_LSB = 2;
    localparam int MISC_CLK_MSB = 3;
    localparam int MISC_PAGE_BIT = 5;
    localparam int MISC_HSYNC_POL_BIT = 6;
    localparam int MISC_VSYNC_POL_BIT = 7;
    localparam logic [7:0] MISC_WRITE_MASK = 8'hEF; // bit 4 reads zero
    localparam logic [7:0] MISC_RESET = 8'h00;
    // dot clock select codes
    localparam logic [1:0] CLK_SEL_25M = 2'h0;
    localparam logic [1:0] CLK_SEL_28M = 2'h1;
    localparam logic [1:0] CLK_SEL_EXT_UNUSED = 2'h2;
    localparam logic [1:0] CLK_SEL_RSVD = 2'h3;
    // sequencer index / reset fields
    localparam int SEQ_IDX_W = 3;
    localparam logic [2:0] SEQ_IDX_RESET = 3'h0;
    localparam logic [2:0] SEQ_IDX_INIT = 3'h0;
    localparam logic [1:0] SEQ_RST_INIT = 2'h0;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // host command codes
    typedef enum logic [1:0] {
        VMO_OP_IO_WR,
        VMO_OP_IO_RD,
        VMO_OP_MEM_RD,
        VMO_OP_MEM_WR
    } vmo_op_t;
    // line counts encoded in sync polarity bits {v,h}
    localparam logic [1:0] POL_200_LINE = 2'h0;
    localparam logic [1:0] POL_350_LINE = 2'h2;
    localparam logic [1:0] POL_400_LINE = 2'h1;
    localparam logic [1:0] POL_480_LINE = 2'h3;
endpackage : vmo_pkg

//--- pkg/vmo_if.sv
// legacy io/memory cycle link between host and device
`timescale 1ns/1ps
interface vmo_if;
    logic io_req;
    logic io_wr;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    logic io_ack;
    logic io_claim;
    logic [7:0] io_rdata;
    logic mem_req;
    logic mem_aperture;
    logic [31:0] mem_addr;
    logic mem_ack;
    logic mem_grant;
    modport device (
        input io_req, io_wr, io_addr, io_wdata, mem_req, mem_aperture, mem_addr,
        output io_ack, io_claim, io_rdata, mem_ack, mem_grant
    );
    modport host (
        output io_req, io_wr, io_addr, io_wdata, mem_req, mem_aperture, mem_addr,
        input io_ack, io_claim, io_rdata, mem_ack, mem_grant
    );
endinterface : vmo_if

//--- core/vmo_port_decode.sv
// combinational io port decoder for the device end
`timescale 1ns/1ps
module vmo_port_decode
    import vmo_pkg::*;
(
    input wire logic [15:0] addr,
    input wire logic wr,
    output logic hit_misc,
    output logic hit_seq_index,
    output logic hit_seq_data,
    output logic hit_crt_range
);
    // both mono and colour ranges are claimed regardless of io select
    always_comb begin
        hit_misc = wr ? (addr == PORT_MISC_WR) : (addr == PORT_MISC_RD);
        hit_seq_index = (addr == PORT_SEQ_INDEX);
        hit_seq_data = (addr == PORT_SEQ_DATA);
        hit_crt_range = ((addr & PORT_RANGE_MASK) == PORT_MONO_BASE)
            || ((addr & PORT_RANGE_MASK) == PORT_COLOUR_BASE);
    end
endmodule : vmo_port_decode

//--- core/vmo_device.sv
// device end: misc output register, sequencer index and reset registers
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - clock code 10 unused, 11 reserved
// - aperture bit gates A0000-BFFFF accesses
// - linear frame buffer access never gated
// - host maps enabled aperture uncacheable
// - io select bit: 0 mono, 1 colour
// - both 3Bx and 3Dx ranges always claimed
// - software sets sync polarities per line count
// - extended modes may leave polarities zero
// - index at 3C4, data through 3C5
// - index three bits, upper bits read zero
// - sequencer reset register has no effect
// - misc written 3C2, read 3CC, resets zero
// - sync polarity bit 1 means negative
module vmo_device
    import vmo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    vmo_if.device bus,
    output logic [1:0] dot_clk_sel,
    output logic dot_clk_valid,
    output logic hsync_neg,
    output logic vsync_neg,
    output logic page_sel,
    output logic colour_emulation,
    output logic aperture_en,
    output logic crt_io_strobe
);
    logic [7:0] misc_output_reg;
    logic [2:0] seq_index_reg;
    logic [1:0] seq_reset_reg;
    logic hit_misc;
    logic hit_seq_index;
    logic hit_seq_data;
    logic hit_crt_range;
    logic io_wr_go;
    logic io_rd_go;
    logic [7:0] read_word;

    // true while the index points at the reset compatibility register
    function automatic logic at_reset_index(input logic [SEQ_IDX_W-1:0] idx);
        at_reset_index = (idx == SEQ_IDX_RESET);
    endfunction : at_reset_index

    // dot clock code field of the misc output register
    function automatic logic [1:0] clk_code(input logic [DATA_W-1:0] misc);
        clk_code = misc[MISC_CLK_MSB:MISC_CLK_LSB];
    endfunction : clk_code

    // only the two fixed oscillators are usable; 10 lost its source, 11 is reserved
    function automatic logic clk_code_usable(input logic [1:0] code);
        clk_code_usable = (code == CLK_SEL_25M) || (code == CLK_SEL_28M);
    endfunction : clk_code_usable

    //////////////////////////////////////////////////////////////////////////
    vmo_port_decode u_decode (
        .addr(bus.io_addr),
        .wr(bus.io_wr),
        .hit_misc(hit_misc),
        .hit_seq_index(hit_seq_index),
        .hit_seq_data(hit_seq_data),
        .hit_crt_range(hit_crt_range)
    );

    assign io_wr_go = bus.io_req && bus.io_wr;
    assign io_rd_go = bus.io_req && !bus.io_wr;

    //////////////////////////////////////////////////////////////////////////
    // misc output register; bit 4 forced low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            misc_output_reg <= MISC_RESET;
        end else if (io_wr_go && hit_misc) begin
            misc_output_reg <= bus.io_wdata & MISC_WRITE_MASK;
        end
    end

    // sequencer index, only low three bits stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_index_reg <= SEQ_IDX_INIT;
        end else if (io_wr_go && hit_seq_index) begin
            seq_index_reg <= bus.io_wdata[SEQ_IDX_W-1:0];
        end
    end

    // reset compatibility bits: stored, read back, drive nothing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seq_reset_reg <= SEQ_RST_INIT;
        end else if (io_wr_go && hit_seq_data && at_reset_index(seq_index_reg)) begin
            seq_reset_reg <= bus.io_wdata[$bits(seq_reset_reg)-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // read mux; unclaimed or non-read cycles return the idle word
    always_comb begin
        read_word = READ_IDLE;
        if (io_rd_go) begin
            if (hit_misc) begin
                read_word = misc_output_reg;
            end else if (hit_seq_index) begin
                read_word = DATA_W'(seq_index_reg);
            end else if (hit_seq_data && at_reset_index(seq_index_reg)) begin
                read_word = DATA_W'(seq_reset_reg);
            end
        end
    end

    // answer one cycle after the request, as a single pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.io_ack <= 1'b0;
        end else begin
            bus.io_ack <= bus.io_req;
        end
    end

    // claim: both crt ranges whatever the io select bit says
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.io_claim <= 1'b0;
        end else begin
            bus.io_claim <= bus.io_req && (hit_misc || hit_seq_index || hit_seq_data
                || hit_crt_range);
        end
    end

    // read data stands for the ack cycle only, so a stale word never lingers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.io_rdata <= READ_IDLE;
        end else begin
            bus.io_rdata <= read_word;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // memory gate: aperture needs enable bit, linear never blocked
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus.mem_ack <= 1'b0;
            bus.mem_grant <= 1'b0;
        end else begin
            bus.mem_ack <= bus.mem_req;
            if (bus.mem_addr >= APERTURE_LO && bus.mem_addr <= APERTURE_HI
                && !bus.mem_aperture) begin
                bus.mem_grant <= 1'b0; // the legacy window is only via aperture cycles
            end else if (bus.mem_aperture) begin
                bus.mem_grant <= bus.mem_req && misc_output_reg[MISC_APER_EN_BIT];
            end else begin
                bus.mem_grant <= bus.mem_req;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // dot clock select and its usability flag, one cycle behind the register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dot_clk_sel <= CLK_SEL_25M;
            dot_clk_valid <= 1'b1;
        end else begin
            dot_clk_sel <= clk_code(misc_output_reg);
            // codes 10 and 11 pick no source; a user must not rely on them
            dot_clk_valid <= clk_code_usable(clk_code(misc_output_reg));
        end
    end

    // sync polarity views: 1 means negative
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hsync_neg <= 1'b0;
            vsync_neg <= 1'b0;
        end else begin
            hsync_neg <= misc_output_reg[MISC_HSYNC_POL_BIT];
            vsync_neg <= misc_output_reg[MISC_VSYNC_POL_BIT];
        end
    end

    // page, emulation and aperture views; port decoding never reads the select bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_sel <= 1'b0;
            colour_emulation <= 1'b0;
            aperture_en <= 1'b0;
        end else begin
            page_sel <= misc_output_reg[MISC_PAGE_BIT];
            colour_emulation <= misc_output_reg[MISC_IO_SEL_BIT];
            aperture_en <= misc_output_reg[MISC_APER_EN_BIT];
        end
    end

    // one pulse per crt range cycle, in step with the ack
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            crt_io_strobe <= 1'b0;
        end else begin
            crt_io_strobe <= bus.io_req && hit_crt_range;
        end
    end
endmodule : vmo_device

//--- core/vmo_host.sv
// host end: issues one legacy io or memory cycle per command
`timescale 1ns/1ps
module vmo_host
    import vmo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    vmo_if.host bus,
    input wire logic cmd_valid,
    input wire vmo_op_t cmd_op,
    input wire logic [31:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic rsp_ok,
    output logic uc_map_aperture
);
    typedef enum {ST_IDLE, ST_WAIT} vmo_hstate_t;
    vmo_hstate_t state_reg;
    logic aper_reg;

    // aperture range test; the host decides the cycle type
    function automatic logic in_aperture(input logic [31:0] a);
        in_aperture = (a >= APERTURE_LO) && (a <= APERTURE_HI);
    endfunction : in_aperture

    //////////////////////////////////////////////////////////////////////////
    // one outstanding cycle; requests are one-cycle pulses
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_rdata <= READ_IDLE;
            rsp_ok <= 1'b0;
            bus.io_req <= 1'b0;
            bus.io_wr <= 1'b0;
            bus.io_addr <= 16'h0000;
            bus.io_wdata <= 8'h00;
            bus.mem_req <= 1'b0;
            bus.mem_aperture <= 1'b0;
            bus.mem_addr <= 32'h0000_0000;
        end else begin
            bus.io_req <= 1'b0;
            bus.mem_req <= 1'b0;
            rsp_valid <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready <= 1'b0;
                        state_reg <= ST_WAIT;
                        bus.io_wr <= (cmd_op == VMO_OP_IO_WR);
                        bus.io_addr <= cmd_addr[15:0];
                        bus.io_wdata <= cmd_wdata;
                        bus.mem_addr <= cmd_addr;
                        // index then data access is software's sequence
                        bus.io_req <= (cmd_op == VMO_OP_IO_WR)
                            || (cmd_op == VMO_OP_IO_RD);
                        bus.mem_req <= (cmd_op == VMO_OP_MEM_RD)
                            || (cmd_op == VMO_OP_MEM_WR);
                        bus.mem_aperture <= in_aperture(cmd_addr);
                    end
                end
                ST_WAIT: begin
                    if (bus.io_ack || bus.mem_ack) begin
                        state_reg <= ST_IDLE;
                        cmd_ready <= 1'b1;
                        rsp_valid <= 1'b1;
                        rsp_rdata <= bus.io_ack ? bus.io_rdata : READ_IDLE;
                        rsp_ok <= bus.io_ack ? bus.io_claim : bus.mem_grant;
                    end
                end
            endcase
        end
    end

    // shadow of aperture enable: window mapped uncacheable while enabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aper_reg <= 1'b0;
            uc_map_aperture <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && cmd_valid && cmd_op == VMO_OP_IO_WR
                && cmd_addr[15:0] == PORT_MISC_WR) begin
                aper_reg <= cmd_wdata[MISC_APER_EN_BIT];
            end
            uc_map_aperture <= aper_reg;
        end
    end
endmodule : vmo_host

//--- tb/vmo_properties.sv
// concurrent checks on the host/device link
`timescale 1ns/1ps
module vmo_properties
    import vmo_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic io_req,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_ack,
    input wire logic io_claim,
    input wire logic [7:0] io_rdata,
    input wire logic mem_req,
    input wire logic mem_aperture,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic mem_grant
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] misc_reg;
    logic [2:0] idx_reg;
    logic rd;
    logic win;
    logic crt;
    assign rd = io_req && !io_wr;
    assign win = mem_addr >= APERTURE_LO && mem_addr <= APERTURE_HI;
    assign crt = (io_addr & PORT_RANGE_MASK) inside {PORT_MONO_BASE, PORT_COLOUR_BASE};
    //////////////////////////////////////////////////////////////////////////
    // shadow of misc output, so reads and the gate can be predicted
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            misc_reg <= MISC_RESET;
        else if (io_req && io_wr && io_addr == PORT_MISC_WR)
            misc_reg <= io_wdata & MISC_WRITE_MASK;
    end
    // shadow of the sequencer index
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            idx_reg <= SEQ_IDX_INIT;
        else if (io_req && io_wr && io_addr == PORT_SEQ_INDEX)
            idx_reg <= io_wdata[2:0];
    end
    //////////////////////////////////////////////////////////////////////////
    io_ack_timing_a: assert property (io_req |=> io_ack)
        else $error("io ack missing");
    io_ack_spur_a: assert property (!io_req |=> !io_ack)
        else $error("io ack without request");
    mem_ack_timing_a: assert property (mem_req |=> mem_ack)
        else $error("memory ack missing");
    mem_ack_spur_a: assert property (!mem_req |=> !mem_ack)
        else $error("memory ack without request");
    crt_both_claimed_a: assert property (io_req && crt |=> io_claim)
        else $error("crt range not claimed");
    index_readback_a: assert property (
        rd && io_addr == PORT_SEQ_INDEX |=> io_rdata == {5'h00, idx_reg})
        else $error("index readback wrong");
    misc_readback_a: assert property (
        rd && io_addr == PORT_MISC_RD |=> io_rdata == misc_reg)
        else $error("misc readback wrong");
    seq_reset_rsvd_a: assert property (
        rd && io_addr == PORT_SEQ_DATA && idx_reg == SEQ_IDX_RESET |=> io_rdata[7:2] == 6'h00)
        else $error("reset register upper bits set");
    seq_other_zero_a: assert property (
        rd && io_addr == PORT_SEQ_DATA && idx_reg != SEQ_IDX_RESET |=> io_rdata == READ_IDLE)
        else $error("unrouted sequencer read not zero");
    aperture_gate_a: assert property (
        mem_req && mem_aperture && win |=> mem_grant == misc_reg[MISC_APER_EN_BIT])
        else $error("aperture gate wrong");
    linear_open_a: assert property (mem_req && !win |=> mem_grant)
        else $error("linear access blocked");
    cover property (mem_req && win && misc_reg[1]);
    cover property (rd && io_addr == PORT_SEQ_DATA && idx_reg == 3'h0);
    cover property (io_req && io_wr && io_addr == PORT_MISC_WR && io_wdata[3:2] == CLK_SEL_RSVD);
endmodule : vmo_properties

//--- tb/test_vga_misc_output_seq_index.sv
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
module test_vga_misc_output_seq_index
    import vmo_pkg::*;
;
    logic ref_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ok, uc_map, gok;
    vmo_op_t cmd_op;
    logic [31:0] cmd_addr;
    logic [7:0] cmd_wdata, rsp_rdata, got, w, misc_m, idx_m, rst_m;
    logic [1:0] dot_sel;
    logic dot_ok, hneg, vneg, page, colour, aper, crt_stb;
    int n_fail, checked;
    int n_crt = 0;
    int exp_q[$];
    vmo_if vif();
    vmo_device vmo_device_inst(.ref_clk(ref_clk), .rst_n(rst_n), .bus(vif.device),
        .dot_clk_sel(dot_sel), .dot_clk_valid(dot_ok), .hsync_neg(hneg), .vsync_neg(vneg),
        .page_sel(page), .colour_emulation(colour), .aperture_en(aper),
        .crt_io_strobe(crt_stb));
    vmo_host vmo_host_inst(.ref_clk(ref_clk), .rst_n(rst_n), .bus(vif.host),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_ok(rsp_ok),
        .uc_map_aperture(uc_map));
    vmo_properties vmo_properties_inst(.ref_clk(ref_clk), .rst_n(rst_n), .io_req(vif.io_req),
        .io_wr(vif.io_wr), .io_addr(vif.io_addr), .io_wdata(vif.io_wdata), .io_ack(vif.io_ack),
        .io_claim(vif.io_claim), .io_rdata(vif.io_rdata), .mem_req(vif.mem_req),
        .mem_aperture(vif.mem_aperture), .mem_addr(vif.mem_addr), .mem_ack(vif.mem_ack),
        .mem_grant(vif.mem_grant));
    //////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", n_fail, checked);
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // one host command; entered and left just after a rising edge
    task automatic cyc(input vmo_op_t op, input logic [31:0] a, input logic [7:0] d);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        // bounded wait: a lost response must not hang the run
        while (rsp_valid !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        if (k >= 20) begin
            n_fail++;
            test_done();
        end
        got = rsp_rdata;
        gok = rsp_ok;
    endtask : cyc
    // write through the host, keeping the reference model in step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(VMO_OP_IO_WR, {16'h0000, a}, d);
        chk(gok, 1'b1);
        if (a == PORT_MISC_WR)
            misc_m = d & 8'hEF;
        if (a == PORT_SEQ_INDEX)
            idx_m = d & 8'h07;
        if (a == PORT_SEQ_DATA && idx_m == 8'h00)
            rst_m = d & 8'h03;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic eok, input logic [7:0] ed);
        exp_q.push_back(ed);
        cyc(VMO_OP_IO_RD, {16'h0000, a}, 8'h00);
        chk(gok, eok);
        chk(got, exp_q.pop_front());
    endtask : rd
    // memory cycle, read or write picked at random: both pass the same gate
    task automatic mem(input logic [31:0] a, input logic eok);
        cyc(w[4] ? VMO_OP_MEM_WR : VMO_OP_MEM_RD, a, w);
        chk(gok, eok);
    endtask : mem
    //////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // count crt strobe pulses, one expected per crt range cycle
    always @(posedge ref_clk) begin
        if (crt_stb === 1'b1) begin
            n_crt <= n_crt + 1;
        end
    end
    // two passes: power-on reset, then a reset in mid-run over dirty state
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = VMO_OP_IO_RD;
        cmd_addr = 32'h0000_0000;
        cmd_wdata = 8'h00;
        n_fail = 0;
        checked = 0;
        w = 8'($urandom(73));
        for (int r = 0; r < 2; r++) begin
            repeat (8) @(posedge ref_clk);
            #1;
            rst_n = 1'b1;
            misc_m = 8'h00;
            idx_m = 8'h00;
            rst_m = 8'h00;
            rd(PORT_MISC_RD, 1'b1, 8'h00);
            rd(PORT_SEQ_INDEX, 1'b1, 8'h00);
            rd(PORT_SEQ_DATA, 1'b1, 8'h00);
            chk({aper, colour, dot_ok}, 3'h1);
            mem(32'h000A_0000, 1'b0);
            mem(32'h0010_0000, 1'b1);
            for (int i = 0; i < 8; i++) begin
                w = 8'($urandom);
                w[3:2] = 2'(i);
                w[7:6] = {i[2], i[0]};
                wr(PORT_MISC_WR, w);
                rd(PORT_MISC_RD, 1'b1, misc_m);
                rd(PORT_MISC_WR, 1'b0, 8'h00);
                chk({dot_sel, dot_ok}, {w[3:2], !w[3]});
                chk({vneg, hneg, page}, {w[7:6], w[5]});
                chk({colour, aper, uc_map}, {w[0], w[1], w[1]});
                mem(32'h000B_FFFF, w[1]);
                mem(32'h2000_0000, 1'b1);
                cyc(VMO_OP_IO_RD, 32'h0000_03B4, 8'h00);
                chk(gok, 1'b1);
                cyc(VMO_OP_IO_WR, 32'h0000_03DA, w);
                chk(gok, 1'b1);
            end
            wr(PORT_SEQ_INDEX, 8'hFF);
            rd(PORT_SEQ_INDEX, 1'b1, 8'h07);
            wr(PORT_SEQ_DATA, 8'h5A);
            rd(PORT_SEQ_DATA, 1'b1, 8'h00);
            wr(PORT_SEQ_INDEX, 8'hF8);
            rd(PORT_SEQ_INDEX, 1'b1, 8'h00);
            wr(PORT_SEQ_DATA, 8'hFF);
            rd(PORT_SEQ_DATA, 1'b1, rst_m);
            rd(PORT_MISC_RD, 1'b1, misc_m);
            wr(PORT_MISC_WR, 8'hFF);
            wr(PORT_SEQ_INDEX, 8'h03);
            rst_n = 1'b0;
        end
        chk(n_crt, 32);
        test_done();
    end
endmodule : test_vga_misc_output_seq_index
